// ---- sct_cfg.svh ----
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

// register offsets
`define SCT_OFS_SAMPLE_RATE_DIVIDER 8'h12
`define SCT_OFS_CONVERTER_TIMING 8'h4e
`define SCT_OFS_SAMPLE_SYNC 8'h4f
`define SCT_OFS_FAST_CAL_CTRL 8'h50
`define SCT_OFS_FAST_TRIM 8'h4d
`define SCT_OFS_CLOCK_RATIO 8'h0a
`define SCT_OFS_SLOW_CLOCK_CTRL 8'h4b

// reset values
`define SCT_RST_SAMPLE_RATE_DIVIDER 16'h0028
`define SCT_RST_CONVERTER_TIMING 16'h0060
`define SCT_RST_SAMPLE_SYNC 16'h2090
`define SCT_RST_FAST_CAL_CTRL 16'h0000
`define SCT_RST_FAST_TRIM_REG 16'h425e
`define SCT_RST_SLOW_CLOCK_CTRL 16'h2612

// field positions
`define SCT_BIT_SYNC_SOURCE 2
`define SCT_BIT_IRQ_INPUT_EN 1
`define SCT_BIT_RATIO_START 5
`define SCT_BIT_SLOW_CLOCK_EN 7

// fast clock model, frequencies in kHz
`define SCT_FAST_NOMINAL_KHZ 32000
`define SCT_FAST_STEP_KHZ 109
`define SCT_FAST_TRIM_DEFAULT 8'h5e
`define SCT_SAMPLE_DIV_FACTOR 4

// timing
`define SCT_MCLK_HZ 100000000
`define SCT_SLOW_HZ 32000
`define SCT_SLOW_DIV_CYCLES (`SCT_MCLK_HZ / `SCT_SLOW_HZ)
`define SCT_LED_PULSE_TICKS 8'h20
`define SCT_SAMPLE_CYCLE_TICKS 8'h80

`endif

// ---- sct_core.sv ----
`include "sct_cfg.svh"

module sct_core
	import sct_pkg::*;
#(
	parameter int SLOW_DIV = `SCT_SLOW_DIV_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire sct_req_s req,
	output logic [15:0] rdata,
	input wire logic irq_pin_in,
	output logic fast_tick,
	output logic slow_tick,
	output logic sample_start,
	output logic cycle_busy,
	output logic led_pulse,
	output logic ratio_ready
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ****************************************
	// register file
	// ****************************************
	logic [15:0] div_reg, timing_reg, sync_reg, cal_reg, trim_reg, slowctl_reg, ratio;
	logic [15:0] next_div_reg, next_timing_reg, next_sync_reg, next_cal_reg, next_trim_reg, next_slowctl_reg;
	logic [15:0] next_rdata;

	function automatic logic [2:0] sct_sel(input logic [7:0] a);
		case (a)
			`SCT_OFS_SAMPLE_RATE_DIVIDER: sct_sel = 3'h1;
			`SCT_OFS_CONVERTER_TIMING: sct_sel = 3'h2;
			`SCT_OFS_SAMPLE_SYNC: sct_sel = 3'h3;
			`SCT_OFS_FAST_CAL_CTRL: sct_sel = 3'h4;
			`SCT_OFS_FAST_TRIM: sct_sel = 3'h5;
			`SCT_OFS_SLOW_CLOCK_CTRL: sct_sel = 3'h6;
			`SCT_OFS_CLOCK_RATIO: sct_sel = 3'h7;
			default: sct_sel = 3'h0;
		endcase
	endfunction : sct_sel

	always_comb begin
		next_div_reg = div_reg;
		next_timing_reg = timing_reg;
		next_sync_reg = sync_reg;
		next_cal_reg = cal_reg;
		next_trim_reg = trim_reg;
		next_slowctl_reg = slowctl_reg;
		next_rdata = rdata;
		if (req.wr) begin
			case (sct_sel(req.addr))
				3'h1: next_div_reg = req.wdata;
				3'h2: next_timing_reg = req.wdata;
				3'h3: next_sync_reg = req.wdata;
				3'h4: next_cal_reg = req.wdata;
				3'h5: next_trim_reg = req.wdata;
				3'h6: next_slowctl_reg = req.wdata;
				default: ;
			endcase
		end
		if (req.rd) begin
			case (sct_sel(req.addr))
				3'h1: next_rdata = div_reg;
				3'h2: next_rdata = timing_reg;
				3'h3: next_rdata = sync_reg;
				3'h4: next_rdata = cal_reg;
				3'h5: next_rdata = trim_reg;
				3'h6: next_rdata = slowctl_reg;
				3'h7: next_rdata = ratio;
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_reg <= `SCT_RST_SAMPLE_RATE_DIVIDER;
			timing_reg <= `SCT_RST_CONVERTER_TIMING;
			sync_reg <= `SCT_RST_SAMPLE_SYNC;
			cal_reg <= `SCT_RST_FAST_CAL_CTRL;
			trim_reg <= `SCT_RST_FAST_TRIM_REG;
			slowctl_reg <= `SCT_RST_SLOW_CLOCK_CTRL;
			rdata <= 16'h0000;
		end else begin
			div_reg <= next_div_reg;
			timing_reg <= next_timing_reg;
			sync_reg <= next_sync_reg;
			cal_reg <= next_cal_reg;
			trim_reg <= next_trim_reg;
			slowctl_reg <= next_slowctl_reg;
			rdata <= next_rdata;
		end
	end

	wire logic [7:0] trim = trim_reg[7:0];
	wire logic src_pin = sync_reg[`SCT_BIT_SYNC_SOURCE];
	wire logic pin_ie = sync_reg[`SCT_BIT_IRQ_INPUT_EN];
	wire logic cal_bit = cal_reg[`SCT_BIT_RATIO_START];
	wire logic slow_en = slowctl_reg[`SCT_BIT_SLOW_CLOCK_EN];
	chk_trim_write: assert property (req.wr && req.addr == `SCT_OFS_FAST_TRIM |=> trim == $past(req.wdata[7:0]))
		else $error("trim register did not take the written value");

	// ****************************************
	// clock generation
	// ****************************************
	// fast oscillator modelled as a phase accumulator on mclk; monotonic in trim
	logic [23:0] acc, next_acc;
	logic [23:0] inc;
	logic [31:0] fast_khz;
	logic [55:0] prod;
	logic [15:0] slow_cnt, next_slow_cnt;
	logic next_fast_tick, next_slow_tick;

	always_comb begin
		fast_khz = 32'(`SCT_FAST_NOMINAL_KHZ) + 32'(trim) * 32'(`SCT_FAST_STEP_KHZ)
			- 32'(`SCT_FAST_TRIM_DEFAULT) * 32'(`SCT_FAST_STEP_KHZ);
		prod = {24'h000000, fast_khz} << 24;
		inc = 24'(prod / 56'(`SCT_MCLK_HZ / 1000));
		{next_fast_tick, next_acc} = {1'b0, acc} + {1'b0, inc};
		next_slow_tick = 1'b0;
		next_slow_cnt = slow_cnt;
		if (!slow_en) begin
			next_slow_cnt = 16'h0000;
		end else if (slow_cnt == 16'(SLOW_DIV - 1)) begin
			next_slow_cnt = 16'h0000;
			next_slow_tick = 1'b1;
		end else begin
			next_slow_cnt = slow_cnt + 16'h0001;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acc <= 24'h000000;
			fast_tick <= 1'b0;
			slow_cnt <= 16'h0000;
			slow_tick <= 1'b0;
		end else begin
			acc <= next_acc;
			fast_tick <= next_fast_tick;
			slow_cnt <= next_slow_cnt;
			slow_tick <= next_slow_tick;
		end
	end
	chk_trim_monotonic: assert property (trim > $past(trim) |-> inc > $past(inc))
		else $error("higher trim did not raise fast clock rate");
	chk_slow_gated: assert property (!$past(slow_en) |-> !slow_tick)
		else $error("slow clock ticked while disabled");

	// ****************************************
	// sample scheduling
	// ****************************************
	logic pin_s1, pin_s2, pin_s3;
	logic [17:0] samp_cnt, next_samp_cnt;
	logic [7:0] cyc_cnt, next_cyc_cnt;
	logic next_sample_start, next_cycle_busy, next_led_pulse, div_hit, trig_edge;

	always_comb begin
		trig_edge = pin_s2 & ~pin_s3;
		div_hit = 1'b0;
		next_samp_cnt = samp_cnt;
		if (src_pin || div_reg == 16'h0000) begin
			next_samp_cnt = 18'h00000;
		end else if (slow_tick) begin
			if (samp_cnt >= 18'(div_reg) * 18'(`SCT_SAMPLE_DIV_FACTOR) - 18'h00001) begin
				next_samp_cnt = 18'h00000;
				div_hit = 1'b1;
			end else begin
				next_samp_cnt = samp_cnt + 18'h00001;
			end
		end
		next_sample_start = !cycle_busy && (src_pin ? trig_edge : div_hit);
		next_cycle_busy = cycle_busy;
		next_cyc_cnt = cyc_cnt;
		if (next_sample_start) begin
			next_cycle_busy = 1'b1;
			next_cyc_cnt = 8'h00;
		end else if (cycle_busy && fast_tick) begin
			if (cyc_cnt == `SCT_SAMPLE_CYCLE_TICKS - 8'h01) begin
				next_cycle_busy = 1'b0;
			end
			next_cyc_cnt = cyc_cnt + 8'h01;
		end
		next_led_pulse = led_pulse;
		if (fast_tick) begin
			next_led_pulse = cycle_busy && next_cycle_busy && next_cyc_cnt < `SCT_LED_PULSE_TICKS;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			samp_cnt <= 18'h00000;
			cyc_cnt <= 8'h00;
			sample_start <= 1'b0;
			cycle_busy <= 1'b0;
			led_pulse <= 1'b0;
		end else begin
			pin_s1 <= irq_pin_in & pin_ie;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			samp_cnt <= next_samp_cnt;
			cyc_cnt <= next_cyc_cnt;
			sample_start <= next_sample_start;
			cycle_busy <= next_cycle_busy;
			led_pulse <= next_led_pulse;
		end
	end
	chk_div_start: assert property (sample_start && !$past(src_pin) |-> $past(slow_tick))
		else $error("divider sample start without slow tick");
	chk_pin_start: assert property (sample_start && $past(src_pin) |-> $past(trig_edge))
		else $error("pin sample start without trigger edge");
	chk_pin_gate: assert property (!pin_ie && !$past(pin_ie) && !$past(pin_ie, 2) |-> !trig_edge)
		else $error("trigger seen with pin input disabled");
	chk_busy_ignore: assert property (sample_start |-> !$past(cycle_busy) ##1 cycle_busy)
		else $error("sample start while a cycle was running");
	chk_led_timebase: assert property ($changed(led_pulse) |-> $past(fast_tick))
		else $error("led pulse edge not on fast clock tick");

	// ****************************************
	// ratio calibration
	// ****************************************
	// done is left only once the start bit reads 0, so a held 1 cannot re-run
	sct_cal_e cal_st, next_cal_st;
	logic [15:0] cal_cnt, next_cal_cnt, next_ratio;
	logic next_ratio_ready;

	always_comb begin
		next_cal_st = cal_st;
		next_cal_cnt = cal_cnt;
		next_ratio = ratio;
		next_ratio_ready = ratio_ready;
		case (cal_st)
			CAL_IDLE: begin
				if (cal_bit) begin
					next_cal_st = CAL_ARM;
					next_ratio_ready = 1'b0;
				end
			end
			CAL_ARM: begin
				if (slow_tick) begin
					next_cal_st = CAL_COUNT;
					next_cal_cnt = 16'h0000;
				end
			end
			CAL_COUNT: begin
				if (slow_tick) begin
					next_cal_st = CAL_DONE;
					next_ratio = cal_cnt;
					next_ratio_ready = 1'b1;
				end else if (fast_tick) begin
					next_cal_cnt = cal_cnt + 16'h0001;
				end
			end
			CAL_DONE: begin
				if (!cal_bit) begin
					next_cal_st = CAL_IDLE;
				end
			end
			default: next_cal_st = CAL_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cal_st <= CAL_IDLE;
			cal_cnt <= 16'h0000;
			ratio <= 16'h0000;
			ratio_ready <= 1'b0;
		end else begin
			cal_st <= next_cal_st;
			cal_cnt <= next_cal_cnt;
			ratio <= next_ratio;
			ratio_ready <= next_ratio_ready;
		end
	end
	chk_cal_begin: assert property (cal_st == CAL_IDLE && cal_bit |=> cal_st == CAL_ARM)
		else $error("ratio measurement did not begin");
	chk_ratio_update: assert property ($changed(ratio) |-> $past(cal_st) == CAL_COUNT && ratio_ready)
		else $error("ratio result changed outside measurement end");
endmodule : sct_core

// ---- sct_host_model.sv ----
`include "sct_cfg.svh"

module sct_host_model
	import sct_pkg::*;
(
	input wire logic mclk,
	output sct_req_s req,
	input wire logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// register access
	// ****************
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req <= '0;
		@(posedge mclk);
		d = rdata;
	endtask : rd
	// source bit at 8'h38 sits outside this block, written anyway as a real host would
	task automatic sel_src(input logic src, input logic ie);
		wr(8'h38, {1'b0, src, 14'h0000});
		wr(`SCT_OFS_SAMPLE_SYNC, {13'h0412, src, ie, 1'b0});
	endtask : sel_src
	task automatic ratio_kick();
		wr(`SCT_OFS_FAST_CAL_CTRL, 16'h0000);
		wr(`SCT_OFS_FAST_CAL_CTRL, 16'h0020);
	endtask : ratio_kick
endmodule : sct_host_model

// ---- sct_pkg.sv ----
package sct_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} sct_req_s;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_ARM,
		CAL_COUNT,
		CAL_DONE
	} sct_cal_e;
endpackage : sct_pkg

// ---- tb_top.sv ----
module tb_top import sct_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic irq_pin = 1'b0;
	sct_req_s req;
	logic [15:0] rdata;
	logic fast_tick, slow_tick, sample_start, cycle_busy, led_pulse, ratio_ready;
	int failures = 0;
	int cmp_count = 0;
	localparam int SDIV = 16;
	sct_core #(.SLOW_DIV(SDIV)) dut_u (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
		.irq_pin_in(irq_pin), .fast_tick(fast_tick), .slow_tick(slow_tick), .sample_start(sample_start),
		.cycle_busy(cycle_busy), .led_pulse(led_pulse), .ratio_ready(ratio_ready));
	sct_host_model host_u (.mclk(mclk), .req(req), .rdata(rdata));
	initial forever #5 mclk = ~mclk;
	// ****************
	// helpers
	// ****************
	task automatic end_sim();
		$display("mismatches %0d of %0d compares", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input int lo, input int hi, input logic [15:0] g);
		cmp_count++;
		if (lo == hi ? 32'(g) !== lo : (^g === 1'bx || 32'(g) < lo || 32'(g) > hi)) begin
			failures++;
			$display("[FAIL] %s expected %0h..%0h seen %0h", n, lo, hi, g);
		end
	endtask : chk
	task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		host_u.rd(a, d);
		chk(n, int'(e), int'(e), d);
	endtask : rchk
	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			failures++;
			$display("[FAIL] wait expected done seen timeout");
			end_sim();
		end
	endtask : tmo
	// counts ticks over n edges, sampled before that edge's updates land
	task automatic run(input int n, output int cf, output int cs, output int ss);
		cf = 0;
		cs = 0;
		ss = 0;
		repeat (n) begin
			@(posedge mclk);
			cf += int'(fast_tick === 1'b1);
			cs += int'(slow_tick === 1'b1);
			ss += int'(sample_start === 1'b1);
		end
	endtask : run
	// ****************
	// scenarios
	// ****************
	task automatic s_reset();
		logic [7:0] a[8] = '{8'h12, 8'h4e, 8'h4f, 8'h50, 8'h4d, 8'h4b, 8'h0a, 8'h33};
		logic [15:0] e[8] = '{16'h0028, 16'h0060, 16'h2090, 16'h0000, 16'h425e, 16'h2612, 16'h0000, 16'h0000};
		foreach (a[i]) rchk("reset value", a[i], e[i]);
	endtask : s_reset
	task automatic s_trim();
		int cf, cs, ss;
		host_u.wr(8'h4d, 16'h4200);
		rchk("trim min", 8'h4d, 16'h4200);
		run(1000, cf, cs, ss);
		chk("fast ticks min", 216, 219, 16'(cf));
		host_u.wr(8'h4d, 16'h42ff);
		run(1000, cf, cs, ss);
		chk("fast ticks max", 494, 497, 16'(cf));
		host_u.wr(8'h4d, 16'h425e);
		run(1000, cf, cs, ss);
		chk("fast ticks default", 319, 321, 16'(cf));
		host_u.wr(8'h0a, 16'h1234);
		rchk("ratio read only", 8'h0a, 16'h0000);
	endtask : s_trim
	task automatic s_slow();
		int cf, cs, ss;
		run(200, cf, cs, ss);
		chk("slow ticks off", 0, 0, 16'(cs));
		host_u.wr(8'h4b, 16'h2692);
		run(200, cf, cs, ss);
		chk("slow ticks on", 12, 13, 16'(cs));
	endtask : s_slow
	task automatic s_cal();
		int k;
		int lo;
		logic [15:0] d;
		host_u.ratio_kick();
		for (k = 0; ratio_ready !== 1'b1 && k < 200; k++) @(posedge mclk);
		tmo(k, 200);
		host_u.rd(8'h0a, d);
		chk("clock ratio", 4, 6, d);
		host_u.wr(8'h50, 16'h0020);
		@(posedge mclk);
		chk("ratio held", 1, 1, {15'h0000, ratio_ready});
		host_u.ratio_kick();
		lo = 0;
		for (k = 0; k < 100; k++) begin
			@(posedge mclk);
			lo += int'(ratio_ready !== 1'b1);
		end
		chk("ratio rerun", 1, 60, 16'(lo));
		chk("ratio ready again", 1, 1, {15'h0000, ratio_ready});
	endtask : s_cal
	task automatic s_div();
		int k, cf, cs, ss;
		host_u.wr(8'h12, 16'h0008);
		for (k = 0; sample_start !== 1'b1 && k < 3000; k++) @(posedge mclk);
		tmo(k, 3000);
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (sample_start !== 1'b1 && k < 3000);
		tmo(k, 3000);
		chk("sample period", 4 * 8 * SDIV, 4 * 8 * SDIV, 16'(k));
		host_u.wr(8'h12, 16'h0000);
		run(1200, cf, cs, ss);
		chk("divider zero", 0, 0, 16'(ss));
	endtask : s_div
	task automatic s_pin();
		int k, cf, cs, ss, cl;
		host_u.sel_src(1'b1, 1'b0);
		irq_pin <= 1'b1;
		run(20, cf, cs, ss);
		chk("pin disabled", 0, 0, 16'(ss));
		irq_pin <= 1'b0;
		host_u.sel_src(1'b1, 1'b1);
		irq_pin <= 1'b1;
		for (k = 0; sample_start !== 1'b1 && k < 20; k++) @(posedge mclk);
		chk("pin latency", 3, 4, 16'(k));
		tmo(k, 20);
		cf = 0;
		cl = 0;
		ss = 0;
		// a second edge lands mid-cycle and must leave no trace
		for (k = 0; cycle_busy === 1'b1 && k < 1000; k++) begin
			@(posedge mclk);
			cf += int'(fast_tick === 1'b1);
			cl += int'(fast_tick === 1'b1 && led_pulse === 1'b1);
			ss += int'(sample_start === 1'b1);
			if (k == 20) irq_pin <= 1'b0;
			if (k == 40) irq_pin <= 1'b1;
		end
		tmo(k, 1000);
		chk("extra starts", 0, 0, 16'(ss));
		chk("cycle ticks", 127, 129, 16'(cf));
		chk("led ticks", 31, 33, 16'(cl));
	endtask : s_pin
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		s_reset();
		s_trim();
		s_slow();
		s_cal();
		s_div();
		s_pin();
		end_sim();
	end
endmodule : tb_top
